/* File: design/usbsf_ack_timer.sv */
// Receive-timeout watchdog for the expected handshake.
`timescale 1ns/100ps
`include "usbsf_params.svh"
module usbsf_ack_timer
    import usbsf_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ack_wait,
    input  wire logic ack_rx,
    output logic      timeout_pulse
);
    localparam int LIMIT = (`USBSF_TIMEOUT_CYCLES < 1) ? 1
                                                     : `USBSF_TIMEOUT_CYCLES;
    typedef struct packed {
        usbsf_to_state_t st;
        logic [7:0]      cnt;
        logic            fire;
    } tmr_t;
    tmr_t r;
    tmr_t next_r;

    always_comb begin
        next_r = r;
        next_r.fire = 1'b0;
        case (r.st)
            USBSF_TO_IDLE: begin
                if (ack_wait && !ack_rx) begin
                    next_r.st = USBSF_TO_WAIT;
                    next_r.cnt = 8'h00;
                end
            end
            USBSF_TO_WAIT: begin
                if (ack_rx) begin
                    next_r.st = USBSF_TO_IDLE;
                end else if (r.cnt == 8'(LIMIT - 1)) begin
                    next_r.st = USBSF_TO_FIRE;
                end else begin
                    next_r.cnt = r.cnt + 8'h01;
                end
            end
            USBSF_TO_FIRE: begin
                next_r.fire = 1'b1;
                next_r.st = USBSF_TO_IDLE;
            end
            default: next_r.st = USBSF_TO_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign timeout_pulse = r.fire;
endmodule

/* File: design/usbsf_apb_port.sv */
// APB slave front end: decodes a one-wait-free access into strobes.
`timescale 1ns/100ps
`include "usbsf_params.svh"
module usbsf_apb_port
    import usbsf_pkg::*;
(
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    output logic             wr_status,
    output logic             wr_mask,
    output logic             wr_ctrl,
    output logic             mapped
);
    logic access;
    assign access = psel && penable;
    assign wr_status = access && pwrite && paddr == `USBSF_OFF_STATUS;
    assign wr_mask   = access && pwrite && paddr == `USBSF_OFF_MASK;
    assign wr_ctrl   = access && pwrite && paddr == `USBSF_OFF_CTRL;
    assign mapped    = paddr == `USBSF_OFF_STATUS ||
                       paddr == `USBSF_OFF_MASK   ||
                       paddr == `USBSF_OFF_CTRL;
endmodule

/* File: design/usbsf_status.sv */
// Status flag register of the USB serial interface engine.
//
// Functional notes
// - Device: SETUP followed by DATA1 sets the sequence fault flag.
// - Device: OUT data PID unlike buffer word expectation sets sequence fault.
// - Host: IN data with unexpected PID sets sequence fault flag.
// - ACK handshake arriving sets acknowledge flag in either role.
// - Missing ACK within turnaround limit sets receive timeout flag.
// - Receive overflow event sets the overflow flag.
// - Bit stuffing violation sets the stuffing error flag.
// - CRC failure sets the checksum failure flag.
// - Device: bus reset from host sets the link reset flag.
// - Device: IN or OUT packet with final marker sets done flag.
// - Host: setup sent with no data stage sets done flag.
// - Host: zero-length IN data sets done flag.
// - Host: IN data with final marker sets done flag.
// - Host: OUT data sent with final marker sets done flag.
// - Device: accepted SETUP sets the setup seen flag.
// - Far end resume signalling sets resume flag in either role.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`include "usbsf_params.svh"
module usbsf_status
    import usbsf_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire usbsf_evt_t    evt,
    input  wire usbsf_bufctl_t bufctl,
    input  wire logic          host_role,
    input  wire logic          connected,
    output logic               irq
);

    // ============================================================
    // State
    // ============================================================
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] mask;
        logic        ctrl_enable;
        logic        after_setup;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        irq;
    } st_t;
    st_t r;
    st_t next_r;

    logic wr_status;
    logic wr_mask;
    logic wr_ctrl;
    logic mapped;
    logic timeout_pulse;

    usbsf_apb_port u_port (
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .wr_status (wr_status),
        .wr_mask   (wr_mask),
        .wr_ctrl   (wr_ctrl),
        .mapped    (mapped)
    );

    usbsf_ack_timer u_timer (
        .pclk          (pclk),
        .presetn       (presetn),
        .ack_wait      (evt.ack_wait && r.ctrl_enable),
        .ack_rx        (evt.ack_rx),
        .timeout_pulse (timeout_pulse)
    );

    function automatic logic [31:0] bit_at(input int pos, input logic v);
        logic [31:0] m;
        m = 32'h00000000;
        m[pos] = v;
        return m;
    endfunction

    // ============================================================
    // Event decoding
    // ============================================================
    logic        dev;
    logic        seq_err;
    logic        done;
    logic [31:0] set_vec;

    always_comb begin
        dev = !host_role;
        seq_err = 1'b0;
        done = 1'b0;
        if (evt.data_pkt && dev) begin
            if (r.after_setup && evt.data_pid == USBSF_PID_DATA1) begin
                seq_err = 1'b1;
            end
            if (evt.data_out && !r.after_setup &&
                evt.data_pid != bufctl.expected_pid) begin
                seq_err = 1'b1;
            end
            if (bufctl.final_buffer_marker) begin
                done = 1'b1;
            end
        end
        if (evt.data_pkt && host_role && !evt.data_out) begin
            if (evt.data_pid != bufctl.expected_pid) begin
                seq_err = 1'b1;
            end
            if (evt.data_zero_len) begin
                done = 1'b1;
            end
            if (bufctl.final_buffer_marker) begin
                done = 1'b1;
            end
        end
        if (host_role && evt.pkt_sent) begin
            if (evt.pkt_sent_setup && !bufctl.data_stage_follows) begin
                done = 1'b1;
            end
            if (!evt.pkt_sent_setup && bufctl.final_buffer_marker) begin
                done = 1'b1;
            end
        end
        if (dev && evt.pkt_sent && bufctl.final_buffer_marker) begin
            done = 1'b1;
        end
        set_vec = bit_at(`USBSF_BIT_SEQ_ERR, seq_err)
            | bit_at(`USBSF_BIT_ACK, evt.ack_rx)
            | bit_at(`USBSF_BIT_STALL, host_role && evt.stall_rx)
            | bit_at(`USBSF_BIT_NAK, host_role && evt.nak_rx)
            | bit_at(`USBSF_BIT_TIMEOUT, timeout_pulse)
            | bit_at(`USBSF_BIT_OVERFLOW, evt.overflow)
            | bit_at(`USBSF_BIT_STUFF, evt.stuff_err)
            | bit_at(`USBSF_BIT_CRC, evt.crc_err)
            | bit_at(`USBSF_BIT_BUS_RESET, dev && evt.bus_reset)
            | bit_at(`USBSF_BIT_DONE, done)
            | bit_at(`USBSF_BIT_SETUP, dev && evt.setup_tok)
            | bit_at(`USBSF_BIT_RESUME, evt.resume_seen);
        if (!r.ctrl_enable) begin
            set_vec = 32'h00000000;
        end
    end

    // ============================================================
    // Register update and bus answers
    // ============================================================
    always_comb begin
        next_r = r;
        if (evt.setup_tok) begin
            next_r.after_setup = 1'b1;
        end else if (evt.data_pkt) begin
            next_r.after_setup = 1'b0;
        end
        // A write of one clears, but an event in the same cycle wins.
        next_r.status = r.status & ~(wr_status ? pwdata : 32'h00000000)
                        & `USBSF_WC_MASK;
        next_r.status = next_r.status | (set_vec & `USBSF_WC_MASK);
        next_r.status[`USBSF_BIT_CONNECTED] = connected;
        if (wr_mask) begin
            next_r.mask = pwdata & `USBSF_WC_MASK;
        end
        if (wr_ctrl) begin
            next_r.ctrl_enable = pwdata[0];
        end
        next_r.ready = psel && !penable;
        next_r.slverr = psel && !penable && !mapped;
        next_r.rdata = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `USBSF_OFF_STATUS: next_r.rdata = r.status;
                `USBSF_OFF_MASK:   next_r.rdata = r.mask;
                `USBSF_OFF_CTRL:   next_r.rdata = {31'h0, r.ctrl_enable};
                default:           next_r.rdata = 32'h00000000;
            endcase
        end
        // Read data is captured in setup, so status seen is one cycle old.
        next_r.irq = |(next_r.status & next_r.mask & `USBSF_WC_MASK);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.status      <= `USBSF_RST_STATUS;
            r.mask        <= `USBSF_RST_MASK;
            r.ctrl_enable <= `USBSF_RST_CTRL;
            r.after_setup <= 1'b0;
            r.rdata       <= 32'h00000000;
            r.ready       <= 1'b0;
            r.slverr      <= 1'b0;
            r.irq         <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata  = r.rdata;
    assign pready  = r.ready;
    assign pslverr = r.slverr;
    assign irq     = r.irq;
endmodule

/* File: shared/usbsf_params.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef USBSF_PARAMS_SVH
`define USBSF_PARAMS_SVH
`define USBSF_OFF_STATUS      12'h050
`define USBSF_OFF_MASK        12'h0F0
`define USBSF_OFF_CTRL        12'h0F4
`define USBSF_BIT_SEQ_ERR     31
`define USBSF_BIT_ACK         30
`define USBSF_BIT_STALL       29
`define USBSF_BIT_NAK         28
`define USBSF_BIT_TIMEOUT     27
`define USBSF_BIT_OVERFLOW    26
`define USBSF_BIT_STUFF       25
`define USBSF_BIT_CRC         24
`define USBSF_BIT_BUS_RESET   19
`define USBSF_BIT_DONE        18
`define USBSF_BIT_SETUP       17
`define USBSF_BIT_CONNECTED   16
`define USBSF_BIT_RESUME      11
`define USBSF_WC_MASK         32'hFF0E0800
`define USBSF_RST_STATUS      32'h00000000
`define USBSF_RST_MASK        32'h00000000
`define USBSF_RST_CTRL        1'b0
`define USBSF_CLK_MHZ         25
// Turnaround limit in bit times at full speed, and the bit time in ps.
`define USBSF_TURNAROUND_BITS 18
`define USBSF_BIT_TIME_PS     83333
`define USBSF_TIMEOUT_CYCLES  ((`USBSF_TURNAROUND_BITS*`USBSF_BIT_TIME_PS)/(1000000/`USBSF_CLK_MHZ))
`endif

/* File: shared/usbsf_pkg.sv */
// Types shared by the status flag logic.
package usbsf_pkg;
    typedef enum logic [1:0] {
        USBSF_PID_DATA0 = 2'h0,
        USBSF_PID_DATA1 = 2'h1
    } usbsf_data_pid_t;

    // Events reported by the receive engine and transaction sequencer.
    typedef struct packed {
        logic            setup_tok;
        logic            data_pkt;
        usbsf_data_pid_t data_pid;
        logic            data_out;
        logic            data_zero_len;
        logic            ack_rx;
        logic            stall_rx;
        logic            nak_rx;
        logic            overflow;
        logic            stuff_err;
        logic            crc_err;
        logic            bus_reset;
        logic            resume_seen;
        logic            pkt_sent;
        logic            pkt_sent_setup;
        logic            ack_wait;
    } usbsf_evt_t;

    // Buffer control word fields from buffer RAM.
    typedef struct packed {
        logic            final_buffer_marker;
        usbsf_data_pid_t expected_pid;
        logic            data_stage_follows;
    } usbsf_bufctl_t;

    typedef enum logic [1:0] {
        USBSF_TO_IDLE = 2'b00,
        USBSF_TO_WAIT = 2'b01,
        USBSF_TO_FIRE = 2'b11
    } usbsf_to_state_t;
endpackage

/* File: test/usbsf_far_end.sv */
// Far end of the bus: turns requests into one-cycle event pulses, and holds the ack_wait level.
`timescale 1ns/100ps
module usbsf_far_end
    import usbsf_pkg::*;
(
    input wire logic   pclk,
    output usbsf_evt_t evt
);
    initial evt = '0;
    // Called just after a rising edge; the pulse stands for one cycle.
    task automatic send(input usbsf_evt_t e);
        evt <= e;
        @(posedge pclk);
        evt <= '0;
    endtask
    task automatic wait_lvl(input logic v);
        evt.ack_wait <= v;
    endtask
endmodule

/* File: test/usbsf_status_chk.sv */
// Port-level assertions for the status flag block.
`timescale 1ns/100ps
module usbsf_status_chk
    import usbsf_pkg::*;
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire usbsf_evt_t    evt,
    input wire usbsf_bufctl_t bufctl,
    input wire logic          host_role,
    input wire logic          connected,
    input wire logic          irq
);
    // ==================================================================
    // Helper logic
    // Events count only once control bit 0 is set, so it is tracked here.
    logic en;
    logic rd;
    assign rd = psel && !penable && !pwrite && paddr == 12'h050;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en <= 1'b0;
        end else if (psel && penable && pwrite && paddr == 12'h0F4) begin
            en <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==================================================================
    // Assertions
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_err;
        psel && !penable && !(paddr inside {12'h050, 12'h0F0, 12'h0F4})
        |=> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("bad unmapped");
    property p_ack; en && evt.ack_rx ##1 rd |=> prdata[30]; endproperty
    a_ack: assert property (p_ack) else $error("ack lost");
    property p_stl;
        en && host_role && evt.stall_rx ##1 rd |=> prdata[29];
    endproperty
    a_stl: assert property (p_stl) else $error("stall lost");
    property p_ovf; en && evt.overflow ##1 rd |=> prdata[26]; endproperty
    a_ovf: assert property (p_ovf) else $error("ovf lost");
    property p_crc; en && evt.crc_err ##1 rd |=> prdata[24]; endproperty
    a_crc: assert property (p_crc) else $error("crc lost");
    property p_brs;
        en && !host_role && evt.bus_reset ##1 rd |=> prdata[19];
    endproperty
    a_brs: assert property (p_brs) else $error("reset lost");
    property p_res; en && evt.resume_seen ##1 rd |=> prdata[11]; endproperty
    a_res: assert property (p_res) else $error("resume lost");
    property p_con; rd |=> prdata[16] == $past(connected, 2); endproperty
    a_con: assert property (p_con) else $error("conn wrong");
endmodule
bind usbsf_status usbsf_status_chk i_usbsf_status_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .evt, .bufctl, .host_role, .connected, .irq);

/* File: test/usbsf_status_tb.sv */
// Self-checking bench of the status flag block.
`timescale 1ns/100ps
`include "usbsf_params.svh"
module usbsf_status_tb
    import usbsf_pkg::*;
;
    logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pe;
    logic          pwrite = 0, hr = 0, conn = 0, aft = 0;
    logic [11:0]   paddr = 12'h0;
    logic [31:0]   pwdata = 32'h0, prdata, q, w, st = 32'h0, msk = 32'h0;
    logic          pready, pslverr, irq;
    usbsf_evt_t    evt, e;
    usbsf_bufctl_t bc = '0;
    int            err_total = 0, n_checks = 0, seed = 32'hE6AE622F;
    always #20 pclk = ~pclk;
    usbsf_status i_usbsf_status (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .evt, .bufctl(bc),
        .host_role(hr), .connected(conn), .irq);
    usbsf_far_end i_usbsf_far_end (.pclk, .evt);
    // ==================================================================
    // Bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Entered just after an edge; leaves one idle cycle behind it.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        pe = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_st;
        apb(1'b0, 12'h050, 32'h0);
        chk(q, st | {15'h0, conn, 16'h0});
        chk({31'h0, irq}, {31'h0, |(st & msk)});
    endtask
    // ==================================================================
    // Reference model of the flag word
    task automatic ev;
        logic [31:0] b;
        b = 32'h0;
        b[30] = e.ack_rx;
        b[29:28] = {2{hr}} & {e.stall_rx, e.nak_rx};
        b[26:24] = {e.overflow, e.stuff_err, e.crc_err};
        b[19] = !hr & e.bus_reset;
        b[17] = !hr & e.setup_tok;
        b[11] = e.resume_seen;
        if (e.data_pkt) begin
            b[31] = (aft & !hr) ? e.data_pid != USBSF_PID_DATA0
                                : e.data_pid != bc.expected_pid;
            b[18] = (hr & e.data_zero_len)
                    | bc.final_buffer_marker;
        end
        if (e.pkt_sent) begin
            b[18] = e.pkt_sent_setup ? !bc.data_stage_follows
                                     : bc.final_buffer_marker;
        end
        aft = !hr & (e.setup_tok | (aft & !e.data_pkt));
        st = st | b;
        i_usbsf_far_end.send(e);
        rd_st;
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==================================================================
    // Sequence
    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_st;
        apb(1'b0, 12'h0F0, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, pe}, 32'h1);
        e = '0;
        e.ack_rx = 1'b1;
        i_usbsf_far_end.send(e);
        rd_st;
        apb(1'b1, 12'h0F4, 32'h1);
        apb(1'b0, 12'h0F4, 32'h0);
        chk(q, 32'h1);
        conn <= 1'b1;
        apb(1'b1, 12'h050, 32'hFFFFFFFF);
        rd_st;
        for (int r = 0; r < 2; r++) begin
            hr <= r[0];
            for (int i = 0; i < 40; i++) begin
                bc <= usbsf_bufctl_t'($random(seed) & 4'hB);
                conn <= 1'($random(seed));
                msk = $random(seed) & `USBSF_WC_MASK;
                apb(1'b1, 12'h0F0, msk);
                apb(1'b0, 12'h0F0, 32'h0);
                chk(q, msk);
                e = usbsf_evt_t'($random(seed));
                e.data_pid = usbsf_data_pid_t'({1'b0, e.data_out});
                e.ack_wait = 1'b0;
                e.data_out = !hr;
                e.data_zero_len &= hr;
                e.setup_tok &= !hr & !e.data_pkt;
                e.pkt_sent &= !e.data_pkt & !e.setup_tok;
                e.pkt_sent_setup &= hr & e.pkt_sent;
                ev;
                w = $random(seed);
                apb(1'b1, 12'h050, w);
                st = st & ~(w & `USBSF_WC_MASK);
                rd_st;
            end
        end
        i_usbsf_far_end.wait_lvl(1'b1);
        repeat (`USBSF_TIMEOUT_CYCLES - 8) @(posedge pclk);
        rd_st;
        repeat (12) @(posedge pclk);
        st[27] = 1'b1;
        rd_st;
        give_verdict;
    end
endmodule
